// [rtl/atp_consts.svh]
// Purpose: offsets, field positions, reset values and counts of the converter control
// Assumes: 8-bit register port, byte-wide registers
// Notes:   definitions only
`ifndef ATP_CONSTS_SVH
`define ATP_CONSTS_SVH

// ==========================================================
// register offsets
`define ATP_OFS_GLOBAL_INTERRUPT_CONTROL   8'h00
`define ATP_OFS_FLAGS1   8'h01
`define ATP_OFS_ENABLES1 8'h02
`define ATP_OFS_PRIO1    8'h03
`define ATP_OFS_FLAGS2   8'h04
`define ATP_OFS_ENABLES2 8'h05
`define ATP_OFS_PRIO2    8'h06
`define ATP_OFS_RESHI    8'h07
`define ATP_OFS_RESLO    8'h08
`define ATP_OFS_CTRL0    8'h09
`define ATP_OFS_CTRL1    8'h0a
`define ATP_OFS_CTRL2    8'h0b
`define ATP_OFS_PORT_A_PINS    8'h0c
`define ATP_OFS_PORT_A_DIRECTION    8'h0d
`define ATP_OFS_PORT_B_PINS    8'h0e
`define ATP_OFS_PORT_B_DIRECTION    8'h0f
`define ATP_OFS_PORT_B_LATCH     8'h10
`define ATP_OFS_PORT_E_PINS    8'h11
`define ATP_OFS_PORT_E_DIRECTION    8'h12
`define ATP_OFS_LATE     8'h13

// ==========================================================
// field positions
`define ATP_BIT_ENABLE   0
`define ATP_BIT_GO       1
`define ATP_BIT_DONE     6
`define ATP_BIT_SPP      7
`define ATP_BIT_ADFM     7

// ==========================================================
// reset values and masks
`define ATP_PORT_A_DIRECTION_RST    8'h7f
`define ATP_PORT_B_DIRECTION_RST    8'hff
`define ATP_PORT_E_DIRECTION_RST    8'h07
`define ATP_PCFG_ALL_AN  4'h0
`define ATP_PCFG_B_DIG   4'h7
`define ATP_CTRL0_MASK   8'h3f
`define ATP_CTRL1_MASK   8'h3f
`define ATP_CTRL2_MASK   8'hbf

// ==========================================================
// trigger and timing
`define ATP_MODE_TRIGGER 4'hb
`define ATP_CONV_TADS    5'd13
`define ATP_FRC_DIV      7'd16
`define ATP_NUM_CH       13

`endif

// [rtl/atp_pkg.sv]
// Purpose: types of the converter control
// Assumes: nothing
// Notes:   constants live in atp_consts.svh
package atp_pkg;
  typedef enum logic [1:0] {
    ATP_IDLE = 2'b00,
    ATP_ACQ  = 2'b01,
    ATP_CONV = 2'b10
  } atp_state_t;
endpackage

// [rtl/atp_tick.sv]
// Purpose: conversion clock tick, one cycle every divisor cycles
// Assumes: divisor of at least 1
// Notes:   restart realigns the first tick
`timescale 1ns/1ps
`default_nettype none
module atp_tick #(
  parameter int W = 7
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         restart,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  logic [W-1:0] count;

  always_ff @(posedge clock) begin
    if (reset || restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= divisor - W'(1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/atp_edge.sv]
// Purpose: one-cycle pulse on each rising edge of a level
// Assumes: input synchronous to clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
module atp_edge (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic level,
  output logic      pulse
);
  logic last;

  always_ff @(posedge clock) begin
    if (reset) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end

  assign pulse = level & ~last;
endmodule
`default_nettype wire

// [rtl/atp_adc_ctrl.sv]
// Purpose: converter control, pin configuration and trigger start
// Assumes: synchronous pins and straps, one clock
// Notes:   analog_code is the front end's digitised pin level
`include "atp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module atp_adc_ctrl
  import atp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        event_trigger,
  input  wire logic [3:0]  compare_unit_mode_field,
  input  wire logic        port_b_pins_analog_reset_select,
  input  wire logic        reset_pin_enable_config,
  input  wire logic        port_a_bit_six_enable,
  input  wire logic        small_package,
  input  wire logic [11:0] analog_code,
  input  wire logic [6:0]  port_a_in,
  input  wire logic [7:0]  port_b_in,
  input  wire logic [3:0]  port_e_in,
  output logic      [6:0]  port_a_out,
  output logic      [6:0]  port_a_oe,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_b_oe,
  output logic      [2:0]  port_e_out,
  output logic      [2:0]  port_e_oe,
  output logic      [3:0]  sample_channel,
  output logic             sample_closed,
  output logic             timer_clear,
  output logic             irq
);
  // ==========================================================
  // registers
  atp_state_t  state;
  logic [7:0]  global_interrupt_control;
  logic [7:0]  flags1;
  logic [7:0]  enables1;
  logic [7:0]  prio1;
  logic [7:0]  flags2;
  logic [7:0]  enables2;
  logic [7:0]  prio2;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;
  logic [3:0]  analog_channel_select;
  logic        go;
  logic        converter_enable_bit;
  logic [1:0]  reference_source_select;
  logic [3:0]  port_analog_config;
  logic        adfm;
  logic [2:0]  acquisition_time_select;
  logic [2:0]  clock_select;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_e;
  logic [6:0]  lat_a;
  logic [7:0]  lat_b;
  logic [2:0]  lat_e;
  logic [4:0]  tad_left;
  logic [11:0] held_code;
  logic [7:0]  next_rdata;
  logic        trig_pulse;
  logic        tad_tick;
  logic        start;
  logic        done;
  logic        trig_mode;
  logic [6:0]  tad_div;
  logic [4:0]  acq_tads;
  logic [12:0] an_mask;
  logic [4:0]  an_count;
  logic        sel_is_out;
  logic        sel_level;
  logic [11:0] conv_code;
  logic        wr_ctrl0;

  // ==========================================================
  // helpers
  atp_edge u_edge (
    .clock (clock),
    .reset (reset),
    .level (event_trigger),
    .pulse (trig_pulse)
  );

  atp_tick #(.W(7)) u_tick (
    .clock   (clock),
    .reset   (reset),
    .restart (start),
    .divisor (tad_div),
    .tick    (tad_tick)
  );

  always_comb begin
    case (clock_select)
      3'h0:    tad_div = 7'd2;
      3'h1:    tad_div = 7'd8;
      3'h2:    tad_div = 7'd32;
      3'h4:    tad_div = 7'd4;
      3'h5:    tad_div = 7'd16;
      3'h6:    tad_div = 7'd64;
      default: tad_div = `ATP_FRC_DIV;
    endcase
  end

  always_comb begin
    case (acquisition_time_select)
      3'h1:    acq_tads = 5'd2;
      3'h2:    acq_tads = 5'd4;
      3'h3:    acq_tads = 5'd6;
      3'h4:    acq_tads = 5'd8;
      3'h5:    acq_tads = 5'd12;
      3'h6:    acq_tads = 5'd16;
      3'h7:    acq_tads = 5'd20;
      default: acq_tads = 5'd0;
    endcase
  end

  // analog channel count from port configuration
  assign an_count = (port_analog_config < 4'h3) ? 5'd13 : 5'd15 - {1'b0, port_analog_config};

  always_comb begin
    for (int i = 0; i < `ATP_NUM_CH; i++) begin
      an_mask[i] = (5'(i) < an_count);
    end
  end

  // selected pin: direction and driven level
  always_comb begin
    case (analog_channel_select)
      4'h0:    {sel_is_out, sel_level} = {~dir_a[0], lat_a[0]};
      4'h1:    {sel_is_out, sel_level} = {~dir_a[1], lat_a[1]};
      4'h2:    {sel_is_out, sel_level} = {~dir_a[2], lat_a[2]};
      4'h3:    {sel_is_out, sel_level} = {~dir_a[3], lat_a[3]};
      4'h4:    {sel_is_out, sel_level} = {~dir_a[5], lat_a[5]};
      4'h5:    {sel_is_out, sel_level} = {~dir_e[0], lat_e[0]};
      4'h6:    {sel_is_out, sel_level} = {~dir_e[1], lat_e[1]};
      4'h7:    {sel_is_out, sel_level} = {~dir_e[2], lat_e[2]};
      4'h8:    {sel_is_out, sel_level} = {~dir_b[2], lat_b[2]};
      4'h9:    {sel_is_out, sel_level} = {~dir_b[3], lat_b[3]};
      4'ha:    {sel_is_out, sel_level} = {~dir_b[1], lat_b[1]};
      4'hb:    {sel_is_out, sel_level} = {~dir_b[4], lat_b[4]};
      4'hc:    {sel_is_out, sel_level} = {~dir_b[0], lat_b[0]};
      default: {sel_is_out, sel_level} = 2'b00;
    endcase
  end

  // driven output level converts as a rail
  assign conv_code = sel_is_out ? {12{sel_level}} : analog_code;

  // ==========================================================
  // start and sequencing
  assign wr_ctrl0  = wr && (addr == `ATP_OFS_CTRL0);
  assign trig_mode = (compare_unit_mode_field == `ATP_MODE_TRIGGER);
  // channel select and direction bits take no part here
  assign start = (state == ATP_IDLE) && converter_enable_bit &&
                 ((trig_pulse && trig_mode) ||
                  (wr_ctrl0 && wdata[`ATP_BIT_GO] && wdata[`ATP_BIT_ENABLE]));
  assign done  = (state == ATP_CONV) && tad_tick && (tad_left == 5'd1);

  always_ff @(posedge clock) begin
    if (reset || !converter_enable_bit) begin
      state    <= ATP_IDLE;
      tad_left <= 5'd0;
    end else begin
      case (state)
        ATP_IDLE: begin
          if (start && acq_tads == 5'd0) begin
            state    <= ATP_CONV;
            tad_left <= `ATP_CONV_TADS;
          end else if (start) begin
            state    <= ATP_ACQ;
            tad_left <= acq_tads;
          end
        end
        ATP_ACQ: begin
          if (wr_ctrl0 && !wdata[`ATP_BIT_GO]) begin
            state <= ATP_IDLE;
          end else if (tad_tick && tad_left == 5'd1) begin
            state    <= ATP_CONV;
            tad_left <= `ATP_CONV_TADS;
          end else if (tad_tick) begin
            tad_left <= tad_left - 5'd1;
          end
        end
        ATP_CONV: begin
          if (wr_ctrl0 && !wdata[`ATP_BIT_GO]) begin
            state <= ATP_IDLE;
          end else if (done) begin
            state <= ATP_IDLE;
          end else if (tad_tick) begin
            tad_left <= tad_left - 5'd1;
          end
        end
        default: state <= ATP_IDLE;
      endcase
    end
  end

  // holding capacitor disconnects as conversion begins
  always_ff @(posedge clock) begin
    if (reset) begin
      held_code <= 12'h000;
    end else if (state != ATP_CONV) begin
      held_code <= conv_code;
    end
  end

  // trigger clears the timer with or without the converter
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_clear <= 1'b0;
    end else begin
      timer_clear <= trig_pulse && trig_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sample_closed  <= 1'b0;
      sample_channel <= 4'h0;
    end else begin
      sample_closed  <= (state == ATP_ACQ) || (state == ATP_IDLE && converter_enable_bit);
      sample_channel <= analog_channel_select;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock) begin
    if (reset) begin
      analog_channel_select <= 4'h0;
      converter_enable_bit  <= 1'b0;
    end else if (wr_ctrl0) begin
      analog_channel_select <= wdata[5:2];
      converter_enable_bit  <= wdata[`ATP_BIT_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      go <= 1'b0;
    end else if (start) begin
      go <= 1'b1;
    end else if (done || !converter_enable_bit || (wr_ctrl0 && !wdata[`ATP_BIT_GO])) begin
      go <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reference_source_select <= 2'b00;
      // strap caught by the synchronous reset
      port_analog_config <= port_b_pins_analog_reset_select ? `ATP_PCFG_ALL_AN : `ATP_PCFG_B_DIG;
    end else if (wr && addr == `ATP_OFS_CTRL1) begin
      reference_source_select <= wdata[5:4];
      port_analog_config      <= wdata[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      adfm                    <= 1'b0;
      acquisition_time_select <= 3'h0;
      clock_select            <= 3'h0;
    end else if (wr && addr == `ATP_OFS_CTRL2) begin
      adfm                    <= wdata[`ATP_BIT_ADFM];
      acquisition_time_select <= wdata[5:3];
      clock_select            <= wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      res_hi <= 8'h00;
      res_lo <= 8'h00;
    end else if (done) begin
      res_hi <= adfm ? {4'h0, held_code[11:8]} : held_code[11:4];
      res_lo <= adfm ? held_code[7:0] : {held_code[3:0], 4'h0};
    end else if (wr && addr == `ATP_OFS_RESHI) begin
      res_hi <= wdata;
    end else if (wr && addr == `ATP_OFS_RESLO) begin
      res_lo <= wdata;
    end
  end

  // ==========================================================
  // interrupt registers: done sets flags1, read clears it, set wins; the others load on write
  always_ff @(posedge clock) begin
    if (reset) begin
      flags1 <= 8'h00;
    end else if (done) begin
      flags1 <= flags1 | (8'h01 << `ATP_BIT_DONE);
    end else if (rd && addr == `ATP_OFS_FLAGS1) begin
      flags1 <= 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      global_interrupt_control   <= 8'h00;
      enables1 <= 8'h00;
      prio1    <= 8'h00;
      flags2   <= 8'h00;
      enables2 <= 8'h00;
      prio2    <= 8'h00;
    end else if (wr) begin
      case (addr)
        `ATP_OFS_GLOBAL_INTERRUPT_CONTROL:   global_interrupt_control   <= wdata;
        `ATP_OFS_ENABLES1: enables1 <= wdata;
        `ATP_OFS_PRIO1:    prio1    <= wdata;
        `ATP_OFS_FLAGS2:   flags2   <= wdata;
        `ATP_OFS_ENABLES2: enables2 <= wdata;
        `ATP_OFS_PRIO2:    prio2    <= wdata;
        default:           global_interrupt_control   <= global_interrupt_control;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags1 & enables1);
    end
  end

  // ==========================================================
  // port registers
  always_ff @(posedge clock) begin
    if (reset) begin
      dir_a  <= `ATP_PORT_A_DIRECTION_RST;
      dir_b  <= `ATP_PORT_B_DIRECTION_RST;
      dir_e  <= `ATP_PORT_E_DIRECTION_RST;
      lat_a  <= 7'h00;
      lat_b  <= 8'h00;
      lat_e  <= 3'h0;
    end else if (wr) begin
      case (addr)
        `ATP_OFS_PORT_A_DIRECTION: dir_a  <= wdata & `ATP_PORT_A_DIRECTION_RST;
        `ATP_OFS_PORT_B_DIRECTION: dir_b  <= wdata;
        `ATP_OFS_PORT_E_DIRECTION: dir_e  <= wdata & `ATP_PORT_E_DIRECTION_RST;
        `ATP_OFS_PORT_A_PINS: lat_a  <= wdata[6:0];
        `ATP_OFS_PORT_B_PINS: lat_b  <= wdata;
        `ATP_OFS_PORT_B_LATCH:  lat_b  <= wdata;
        `ATP_OFS_PORT_E_PINS: lat_e  <= wdata[2:0];
        `ATP_OFS_LATE:  lat_e  <= wdata[2:0];
        default:        lat_b  <= lat_b;
      endcase
    end
  end

  // port a bit six drives only when the oscillator frees it
  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_out <= 7'h00;
      port_a_oe  <= 7'h00;
      port_b_out <= 8'h00;
      port_b_oe  <= 8'h00;
      port_e_out <= 3'h0;
      port_e_oe  <= 3'h0;
    end else begin
      port_a_out <= lat_a & {port_a_bit_six_enable, 6'h3f};
      port_a_oe  <= ~dir_a[6:0] & {port_a_bit_six_enable, 6'h3f};
      port_b_out <= lat_b;
      port_b_oe  <= ~dir_b;
      port_e_out <= small_package ? 3'h0 : lat_e;
      port_e_oe  <= small_package ? 3'h0 : ~dir_e[2:0];
    end
  end

  // ==========================================================
  // read back
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      `ATP_OFS_GLOBAL_INTERRUPT_CONTROL:   next_rdata = global_interrupt_control;
      `ATP_OFS_FLAGS1:   next_rdata = flags1 & {~small_package, 7'h7f};
      `ATP_OFS_ENABLES1: next_rdata = enables1 & {~small_package, 7'h7f};
      `ATP_OFS_PRIO1:    next_rdata = prio1 & {~small_package, 7'h7f};
      `ATP_OFS_FLAGS2:   next_rdata = flags2;
      `ATP_OFS_ENABLES2: next_rdata = enables2;
      `ATP_OFS_PRIO2:    next_rdata = prio2;
      `ATP_OFS_RESHI:    next_rdata = res_hi;
      `ATP_OFS_RESLO:    next_rdata = res_lo;
      // top bits unimplemented
      `ATP_OFS_CTRL0:    next_rdata = {2'b00, analog_channel_select, go, converter_enable_bit};
      `ATP_OFS_CTRL1:    next_rdata = {2'b00, reference_source_select, port_analog_config};
      `ATP_OFS_CTRL2:    next_rdata = {adfm, 1'b0, acquisition_time_select, clock_select};
      `ATP_OFS_PORT_A_PINS:    next_rdata = {1'b0, port_a_in[6] & port_a_bit_six_enable,
                                       port_a_in[5] & ~an_mask[4], port_a_in[4],
                                       port_a_in[3:0] & ~an_mask[3:0]};
      `ATP_OFS_PORT_A_DIRECTION:    next_rdata = {1'b0, dir_a[6] & port_a_bit_six_enable, dir_a[5:0]};
      `ATP_OFS_PORT_B_PINS:    next_rdata = {port_b_in[7:5], port_b_in[4] & ~an_mask[11],
                                       port_b_in[3] & ~an_mask[9], port_b_in[2] & ~an_mask[8],
                                       port_b_in[1] & ~an_mask[10], port_b_in[0] & ~an_mask[12]};
      `ATP_OFS_PORT_B_DIRECTION:    next_rdata = dir_b;
      `ATP_OFS_PORT_B_LATCH:     next_rdata = lat_b;
      `ATP_OFS_PORT_E_PINS:    next_rdata = small_package ? 8'h00 :
                                      {4'h0, port_e_in[3] & ~reset_pin_enable_config,
                                       port_e_in[2:0] & ~an_mask[7:5]};
      `ATP_OFS_PORT_E_DIRECTION:    next_rdata = small_package ? 8'h00 : {5'h00, dir_e[2:0]};
      `ATP_OFS_LATE:     next_rdata = small_package ? 8'h00 : {5'h00, lat_e};
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_TRIG_START: assert property (
    trig_pulse && trig_mode && converter_enable_bit && state == ATP_IDLE && !wr_ctrl0
    |=> go && state != ATP_IDLE) else $error("accepted trigger did not start");
  AST_TRIG_OFF: assert property (
    trig_pulse && trig_mode && !converter_enable_bit && !wr_ctrl0 |=> !go && timer_clear)
    else $error("disabled converter reacted to trigger");
  AST_BAD_MODE: assert property (
    trig_pulse && !trig_mode && state == ATP_IDLE && !wr_ctrl0 |=> state == ATP_IDLE)
    else $error("trigger started with wrong mode");
  AST_TIMER_PULSE: assert property (
    timer_clear |-> $past(trig_pulse) && !$past(timer_clear))
    else $error("timer clear without single trigger");
  AST_ONCE: assert property (
    event_trigger && $past(event_trigger) |-> !trig_pulse)
    else $error("trigger acted twice");
  AST_ACQ_FIRST: assert property (
    start && acq_tads != 5'd0 |=> state == ATP_ACQ ##1 state != ATP_CONV)
    else $error("conversion skipped acquisition");
  AST_PORT_A_PINS_ANALOG: assert property (
    rd && addr == `ATP_OFS_PORT_A_PINS && an_mask[0] |=> !rdata[0])
    else $error("analog pin read nonzero");
  AST_SMALL_E: assert property (
    rd && addr == `ATP_OFS_PORT_E_PINS && small_package |=> rdata == 8'h00)
    else $error("port e visible on small package");
  AST_A6_HIDDEN: assert property (
    rd && addr == `ATP_OFS_PORT_A_DIRECTION && !port_a_bit_six_enable |=> rdata[7:6] == 2'b00)
    else $error("port a bit six visible");
  AST_CTRL0_TOP: assert property (
    rd && addr == `ATP_OFS_CTRL0 |=> rdata[7:6] == 2'b00)
    else $error("unimplemented bits nonzero");
  AST_E3_STRAP: assert property (
    rd && addr == `ATP_OFS_PORT_E_PINS && reset_pin_enable_config |=> !rdata[3])
    else $error("port e bit three visible");
endmodule
`default_nettype wire

// [verif/atp_cmp_model.sv]
// Purpose: compare unit trigger source and timer counter
// Assumes: shares the converter control clock
// Notes:   trigger is a one-cycle pulse per request
`timescale 1ns/1ps
`default_nettype none
module atp_cmp_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        fire,
  input  wire logic [3:0]  trig_mode,
  input  wire logic        timer_clear,
  output logic             event_trigger,
  output logic      [3:0]  compare_unit_mode_field,
  output logic      [15:0] timer
);
  // ==========================================================
  // trigger and mode
  always_ff @(posedge clock) begin
    event_trigger <= fire & ~reset;
  end
  always_ff @(posedge clock) begin
    compare_unit_mode_field <= trig_mode;
  end
  // ==========================================================
  // timer counter
  always_ff @(posedge clock) begin
    if (reset || timer_clear) begin
      timer <= 16'h0000;
    end else begin
      timer <= timer + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench of the converter control
// Assumes: port B strap resets pins analog
// Notes:   firmware side lives in the tasks
`include "atp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock, reset, wr, rd, fire, six_en;
  logic        event_trigger, timer_clear, irq;
  logic        pb_sel, rst_pin_cfg, small_pkg, closed;
  logic [6:0]  pa_out, pa_oe;
  logic [7:0]  pb_out, pb_oe;
  logic [2:0]  pe_out, pe_oe;
  logic [3:0]  chan;
  logic [7:0]  addr, wdata, rdata, port_b_in;
  logic [6:0]  port_a_in;
  logic [3:0]  trig_mode, cmp_mode;
  logic [11:0] analog_code;
  logic [15:0] timer;
  int          fails, n_compared;

  atp_adc_ctrl uut (
    .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .event_trigger(event_trigger), .compare_unit_mode_field(cmp_mode),
    .port_b_pins_analog_reset_select(pb_sel), .reset_pin_enable_config(rst_pin_cfg),
    .port_a_bit_six_enable(six_en), .small_package(small_pkg), .analog_code(analog_code),
    .port_a_in(port_a_in), .port_b_in(port_b_in), .port_e_in(4'hf),
    .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_out(pb_out), .port_b_oe(pb_oe),
    .port_e_out(pe_out), .port_e_oe(pe_oe), .sample_channel(chan), .sample_closed(closed),
    .timer_clear(timer_clear), .irq(irq));

  atp_cmp_model cmp (
    .clock(clock), .reset(reset), .fire(fire), .trig_mode(trig_mode),
    .timer_clear(timer_clear), .event_trigger(event_trigger),
    .compare_unit_mode_field(cmp_mode), .timer(timer));

  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic fire_trig(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1;
      n = n + {7'h00, timer_clear};
    end
    chk("timer_clear", n, exp);
    if (exp == 8'h01) begin
      chk("timer", timer[7:0], 8'h02);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] a[6] = '{`ATP_OFS_PORT_A_DIRECTION, `ATP_OFS_PORT_B_DIRECTION, `ATP_OFS_PORT_E_DIRECTION,
                         `ATP_OFS_CTRL1, `ATP_OFS_CTRL0, 8'h20};
    logic [7:0] e[6] = '{`ATP_PORT_A_DIRECTION_RST, `ATP_PORT_B_DIRECTION_RST, `ATP_PORT_E_DIRECTION_RST,
                         8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd_reg(a[i], d);
      chk("reset", d, e[i]);
    end
  endtask

  task automatic t_port();
    logic [7:0] d;
    rd_reg(`ATP_OFS_PORT_B_PINS, d);
    chk("port_b_pins", d, 8'he0);
    rd_reg(`ATP_OFS_PORT_A_PINS, d);
    chk("port_a_pins", d, 8'h50);
    six_en <= 1'b0;
    rd_reg(`ATP_OFS_PORT_A_PINS, d);
    chk("port_a_pins_six", d, 8'h10);
    rd_reg(`ATP_OFS_PORT_A_DIRECTION, d);
    chk("port_a_direction_six", d, 8'h3f);
    wr_reg(`ATP_OFS_CTRL1, 8'h0f);
    rd_reg(`ATP_OFS_PORT_B_PINS, d);
    chk("port_b_pins_dig", d, 8'hff);
    rd_reg(`ATP_OFS_PORT_A_PINS, d);
    chk("port_a_pins_dig", d, 8'h3f);
    wr_reg(`ATP_OFS_PORT_B_DIRECTION, 8'h0f);
    wr_reg(`ATP_OFS_PORT_B_LATCH, 8'h5a);
    rd_reg(`ATP_OFS_PORT_B_LATCH, d);
    chk("port_b_latch", d, 8'h5a);
    chk("pb_pins", pb_out & pb_oe, 8'h50);
  endtask

  task automatic conv(input logic [7:0] hi, input logic [7:0] lo, input logic q);
    logic [7:0] d;
    fire_trig(8'h01);
    rd_reg(`ATP_OFS_CTRL0, d);
    chk("go", d, 8'h03);
    for (int i = 0; i < 100 && d[1] !== 1'b0; i++) begin
      rd_reg(`ATP_OFS_CTRL0, d);
    end
    chk("done", d, 8'h01);
    if (d[1] !== 1'b0) begin
      test_done();
    end
    chk("irq", {7'h00, irq}, {7'h00, q});
    rd_reg(`ATP_OFS_FLAGS1, d);
    chk("flag", d, 8'h40);
    rd_reg(`ATP_OFS_FLAGS1, d);
    chk("flag_clr", d, 8'h00);
    chk("irq_clr", {7'h00, irq}, 8'h00);
    rd_reg(`ATP_OFS_RESHI, d);
    chk("res_hi", d, hi);
    rd_reg(`ATP_OFS_RESLO, d);
    chk("res_lo", d, lo);
  endtask

  task automatic t_conv();
    wr_reg(`ATP_OFS_CTRL2, 8'h88);
    wr_reg(`ATP_OFS_ENABLES1, 8'h40);
    wr_reg(`ATP_OFS_CTRL0, 8'h01);
    conv(8'h0a, 8'h5c, 1'b1);
    wr_reg(`ATP_OFS_PORT_A_DIRECTION, 8'h3e);
    wr_reg(`ATP_OFS_PORT_A_PINS, 8'h41);
    wr_reg(`ATP_OFS_ENABLES1, 8'h00);
    conv(8'h0f, 8'hff, 1'b0);
    chk("pa_oe", {1'b0, pa_oe}, 8'h01);
    chk("pa_out", {1'b0, pa_out}, 8'h01);
  endtask

  task automatic t_off();
    logic [7:0] d;
    wr_reg(`ATP_OFS_CTRL0, 8'h00);
    fire_trig(8'h01);
    rd_reg(`ATP_OFS_CTRL0, d);
    chk("off", d, 8'h00);
    wr_reg(`ATP_OFS_CTRL0, 8'h15);
    trig_mode <= 4'h3;
    fire_trig(8'h00);
    rd_reg(`ATP_OFS_CTRL0, d);
    chk("mode", d, 8'h15);
    chk("chan", {3'h0, closed, chan}, 8'h15);
  endtask

  task automatic t_strap();
    logic [7:0] d;
    @(posedge clock);
    pb_sel <= 1'b0;
    reset  <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd_reg(`ATP_OFS_CTRL1, d);
    chk("strap", d, 8'h07);
    rd_reg(`ATP_OFS_PORT_E_PINS, d);
    chk("port_e_pins", d, 8'h08);
    rst_pin_cfg <= 1'b1;
    wr_reg(`ATP_OFS_PORT_E_DIRECTION, 8'h00);
    rd_reg(`ATP_OFS_PORT_E_PINS, d);
    chk("port_e_pins_e3", d, 8'h00);
    chk("pe_pins", {2'b00, pe_out, pe_oe}, 8'h07);
    rst_pin_cfg <= 1'b0;
    small_pkg   <= 1'b1;
    rd_reg(`ATP_OFS_PORT_E_PINS, d);
    chk("port_e_pins_small", d, 8'h00);
    chk("pe_small", {2'b00, pe_out, pe_oe}, 8'h00);
  endtask

  // ==========================================================
  // clock and main sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    reset = 1'b1;
    {wr, rd, fire, addr, wdata, rst_pin_cfg, small_pkg} = '0;
    pb_sel = 1'b1;
    six_en = 1'b1;
    port_b_in = 8'hff;
    port_a_in = 7'h7f;
    trig_mode = `ATP_MODE_TRIGGER;
    analog_code = 12'ha5c;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_port();
    t_conv();
    t_off();
    t_strap();
    test_done();
  end
endmodule
`default_nettype wire
